//--- rtl/mcbh_edge_det.sv
// ==========================================================
// Frame edge detector
module mcbh_edge_det (
    input  wire logic   clock,
    input  wire logic   nrst,
    input  wire logic   frameValid,
    input  wire logic [7:0] cmdByte2,
    input  wire logic [7:0] cmdByte3,
    mcbh_edge_if.src    edges
);
    logic [7:0] prev2_q;
    logic [7:0] prev2_d;
    logic [7:0] cur3_q;
    logic [7:0] cur3_d;

    // Edges only exist in the cycle a frame arrives
    always_comb begin
        prev2_d = frameValid ? cmdByte2 : prev2_q;
        cur3_d  = frameValid ? cmdByte3 : cur3_q;
    end

    always_ff @(posedge clock) begin
        if (!nrst) begin
            prev2_q <= mcbh_pkg::CmdReset;
            cur3_q  <= mcbh_pkg::CmdReset;
        end else begin
            prev2_q <= prev2_d;
            cur3_q  <= cur3_d;
        end
    end

    // Compare each frame against the one before it
    assign edges.rise2 = frameValid ? (cmdByte2 & ~prev2_q) : 8'h00;
    assign edges.fall2 = frameValid ? (~cmdByte2 & prev2_q) : 8'h00;
    assign edges.bits2 = frameValid ? cmdByte2 : prev2_q;
    assign edges.bits3 = frameValid ? cmdByte3 : cur3_q;
endmodule

//--- rtl/mcbh_edge_if.sv
// ==========================================================
// Edge results of one command frame
interface mcbh_edge_if;
    logic [7:0] bits2;
    logic [7:0] rise2;
    logic [7:0] fall2;
    logic [7:0] bits3;

    modport src (output bits2, output rise2, output fall2, output bits3);
    modport dst (input bits2, input rise2, input fall2, input bits3);
endinterface

//--- rtl/mcbh_pkg.sv
package mcbh_pkg;

    // ==========================================================
    // Command byte 2 bit positions
    localparam int CancelBit = 0;
    localparam int HoldBit   = 1;
    localparam int JogBit    = 3;
    localparam int StepBit   = 4;
    localparam int StaBit    = 5;
    localparam int TblBit    = 6;
    localparam int HomeBit   = 7;

    // ==========================================================
    // Command byte 3 bit positions
    localparam int IncBit = 0;
    localparam int DirBit = 1;

    // ==========================================================
    // Status byte 2 and 3 bit positions
    localparam int BusyBit  = 0;
    localparam int HoldRBit = 1;
    localparam int HomePBit = 3;
    localparam int NearBit  = 4;
    localparam int InPosBit = 5;
    localparam int NotBit   = 6;
    localparam int FwdBit   = 7;

    // ==========================================================
    // Reset values and widths
    localparam logic [7:0] CmdReset  = 8'h00;
    localparam logic [7:0] StatReset = 8'h00;
    localparam int         DistW     = 32;
    localparam int         DataW     = 32;

    // ==========================================================
    // Move kinds sent to the motion core
    typedef enum logic [2:0] {
        MCBH_MV_NONE = 3'h0,
        MCBH_MV_JOG  = 3'h1,
        MCBH_MV_STEP = 3'h3,
        MCBH_MV_STA  = 3'h2,
        MCBH_MV_TBL  = 3'h6,
        MCBH_MV_HOME = 3'h7
    } mcbh_move_e;

    // ==========================================================
    // Sequencer states, Gray along idle-run-stop; stop to idle flips both bits
    typedef enum logic [1:0] {
        MCBH_IDLE = 2'h0,
        MCBH_RUN  = 2'h1,
        MCBH_STOP = 2'h3
    } mcbh_state_e;

endpackage

//--- rtl/mcbh_preset_sel.sv
// ==========================================================
// Fixed-distance preset selector
module mcbh_preset_sel (
    input  wire logic [1:0]              sel,
    input  wire logic [mcbh_pkg::DistW-1:0] presetDistance0,
    input  wire logic [mcbh_pkg::DistW-1:0] presetDistance1,
    input  wire logic [mcbh_pkg::DistW-1:0] presetDistance2,
    input  wire logic [mcbh_pkg::DistW-1:0] presetDistance3,
    output logic      [mcbh_pkg::DistW-1:0] distance
);
    // Selector 0..3 picks one of four preset distances
    always_comb begin
        case (sel)
            2'h0:    distance = presetDistance0;
            2'h1:    distance = presetDistance1;
            2'h2:    distance = presetDistance2;
            default: distance = presetDistance3;
        endcase
    end
endmodule

//--- rtl/mcbh_top.sv
// What this block does
// - Rising fixed-distance bit starts a preset-distance move from present position.
// - Fixed-distance bit falling mid-move decelerates to stop, drops remaining travel.
// - Command data selector 0..3 picks one of four preset distances.
// - Direction bit 0 means positive, 1 negative; motion follows it.
// - Direction used for manual, fixed-distance, station moves; ignored otherwise.
// - Rising station bit starts a move to the commanded station number.
// - Station bit falling mid-move decelerates to stop, cancels remaining travel.
// - Station number absolute when relative selector 0, relative when 1.
// - Rising point-table bit starts a move using the commanded entry.
// - Point-table bit falling mid-move decelerates to stop, cancels travel.
// - Rising origin search bit starts search of configured mode.
// - Origin bit falling stops search; re-setting it does not resume.
// - Relative selector 0 absolute, 1 relative for station and table moves.
// - Status bytes 2 and 3 laid out with flags and zero bits.
// - Progressing flag high while a move executes and motion is output.
// - Progressing flag cleared on completion, cancel or other stop.
// - Holding flag high while a host hold request lasts during a running move.
// - Manual feed acknowledge follows its command bit even if unrunnable.
// - Fixed-distance acknowledge follows its command bit even if unrunnable.
// - Station acknowledge follows its command bit even if unrunnable.
// - Rising manual feed bit starts continuous motion until bit falls.
module mcbh_top (
    input  wire logic                        clock,
    input  wire logic                        nrst,
    input  wire logic                        frameValid,
    input  wire logic [7:0]                  cmdByte2,
    input  wire logic [7:0]                  cmdByte3,
    input  wire logic [mcbh_pkg::DataW-1:0]  cmdData,
    input  wire logic [mcbh_pkg::DistW-1:0]  presetDistance0,
    input  wire logic [mcbh_pkg::DistW-1:0]  presetDistance1,
    input  wire logic [mcbh_pkg::DistW-1:0]  presetDistance2,
    input  wire logic [mcbh_pkg::DistW-1:0]  presetDistance3,
    input  wire logic [3:0]                  originSearchModeParam,
    input  wire logic                        servoReady,
    input  wire logic                        motionDone,
    input  wire logic                        motionStopped,
    input  wire logic                        homePositionFlag,
    input  wire logic                        nearFlag,
    input  wire logic                        inPositionFlag,
    input  wire logic                        reverseLimitInput,
    input  wire logic                        forwardLimitInput,
    output logic                             moveStart,
    output logic [2:0]                       moveKind,
    output logic                             moveDecel,
    output logic                             moveHold,
    output logic                             moveNegative,
    output logic                             moveRelative,
    output logic [mcbh_pkg::DistW-1:0]       moveDistance,
    output logic [mcbh_pkg::DataW-1:0]       moveTarget,
    output logic [3:0]                       moveOriginMode,
    output logic [7:0]                       statusByte2,
    output logic [7:0]                       statusByte3
);
    // ==========================================================
    // Frame edges
    mcbh_edge_if edges ();

    mcbh_edge_det uEdge (
        .clock     (clock),
        .nrst      (nrst),
        .frameValid(frameValid),
        .cmdByte2  (cmdByte2),
        .cmdByte3  (cmdByte3),
        .edges     (edges)
    );

    // Preset follows the low data bits every cycle; only the value
    // on the starting frame is latched into the move
    logic [mcbh_pkg::DistW-1:0] presetSel;

    mcbh_preset_sel uSel (
        .sel            (cmdData[1:0]),
        .presetDistance0(presetDistance0),
        .presetDistance1(presetDistance1),
        .presetDistance2(presetDistance2),
        .presetDistance3(presetDistance3),
        .distance       (presetSel)
    );

    // ==========================================================
    // Sequencer state
    mcbh_pkg::mcbh_state_e state_q;
    mcbh_pkg::mcbh_state_e state_d;
    mcbh_pkg::mcbh_move_e  kind_q;
    mcbh_pkg::mcbh_move_e  kind_d;

    // One-cycle pulses to the motion core
    logic                  start_q;
    logic                  start_d;
    logic                  decel_q;
    logic                  decel_d;

    // Hold level and move parameters
    logic                  hold_q;
    logic                  hold_d;
    logic                  neg_q;
    logic                  neg_d;
    logic                  rel_q;
    logic                  rel_d;
    logic [mcbh_pkg::DistW-1:0] dist_q;
    logic [mcbh_pkg::DistW-1:0] dist_d;
    logic [mcbh_pkg::DataW-1:0] tgt_q;
    logic [mcbh_pkg::DataW-1:0] tgt_d;
    logic [3:0]            omode_q;
    logic [3:0]            omode_d;

    // Status byte registers
    logic [7:0]            st2_q;
    logic [7:0]            st2_d;
    logic [7:0]            st3_q;
    logic [7:0]            st3_d;

    // Frame view: live bytes on a frame, last frame otherwise
    logic [7:0] b2;
    logic [7:0] r2;
    logic [7:0] f2;
    logic [7:0] b3;
    logic       running;
    logic       ownBitFell;
    logic       stopReq;
    logic       busy;

    assign b2 = edges.bits2;
    assign r2 = edges.rise2;
    assign f2 = edges.fall2;
    assign b3 = edges.bits3;
    assign running = (state_q == mcbh_pkg::MCBH_RUN);

    // ==========================================================
    // Stop detection
    // Falling edge of the bit that owns the running move; falls
    // of other bits leave the move alone
    always_comb begin
        case (kind_q)
            mcbh_pkg::MCBH_MV_JOG:  ownBitFell = f2[mcbh_pkg::JogBit];
            mcbh_pkg::MCBH_MV_STEP: ownBitFell = f2[mcbh_pkg::StepBit];
            mcbh_pkg::MCBH_MV_STA:  ownBitFell = f2[mcbh_pkg::StaBit];
            mcbh_pkg::MCBH_MV_TBL:  ownBitFell = f2[mcbh_pkg::TblBit];
            mcbh_pkg::MCBH_MV_HOME: ownBitFell = f2[mcbh_pkg::HomeBit];
            default:                ownBitFell = 1'b0;
        endcase
    end

    // Cancel or a dropped command bit both end the move; cancel
    // counts on its rise, so a bit left set blocks no later move
    assign stopReq = ownBitFell | r2[mcbh_pkg::CancelBit];

    // ==========================================================
    // Move sequencing
    // Start selection, stop handling and completion
    always_comb begin
        state_d = state_q;
        kind_d  = kind_q;
        start_d = 1'b0;
        decel_d = 1'b0;
        dist_d  = dist_q;
        tgt_d   = tgt_q;
        neg_d   = neg_q;
        rel_d   = rel_q;
        omode_d = omode_q;
        case (state_q)
            mcbh_pkg::MCBH_IDLE: begin
                // Only one start per frame; origin search has top priority
                // and a servo that is off simply ignores the request
                if (servoReady && (r2[7:3] != 5'h00)) begin
                    start_d = 1'b1;
                    state_d = mcbh_pkg::MCBH_RUN;
                    rel_d   = b3[mcbh_pkg::IncBit];
                    neg_d   = 1'b0;
                    tgt_d   = cmdData;
                    dist_d  = '0;
                    if (r2[mcbh_pkg::HomeBit]) begin
                        kind_d  = mcbh_pkg::MCBH_MV_HOME;
                        omode_d = originSearchModeParam;
                    end else if (r2[mcbh_pkg::TblBit]) begin
                        // Entry data sets the way; direction stays 0
                        kind_d = mcbh_pkg::MCBH_MV_TBL;
                    end else if (r2[mcbh_pkg::StaBit]) begin
                        kind_d = mcbh_pkg::MCBH_MV_STA;
                        neg_d  = b3[mcbh_pkg::DirBit];
                    end else if (r2[mcbh_pkg::StepBit]) begin
                        kind_d = mcbh_pkg::MCBH_MV_STEP;
                        dist_d = presetSel;
                        neg_d  = b3[mcbh_pkg::DirBit];
                        // Always measured from the present position
                        rel_d  = 1'b1;
                    end else begin
                        // Manual feed is the only kind left
                        kind_d = mcbh_pkg::MCBH_MV_JOG;
                        neg_d  = b3[mcbh_pkg::DirBit];
                    end
                end
            end
            mcbh_pkg::MCBH_RUN: begin
                // New starts are dropped, not queued; a stop outranks
                // a completion that lands in the same cycle
                if (stopReq) begin
                    decel_d = 1'b1;
                    state_d = mcbh_pkg::MCBH_STOP;
                end else if (motionDone) begin
                    state_d = mcbh_pkg::MCBH_IDLE;
                    kind_d  = mcbh_pkg::MCBH_MV_NONE;
                end
            end
            mcbh_pkg::MCBH_STOP: begin
                // Remaining travel is dropped; no resume of a search
                if (motionStopped) begin
                    state_d = mcbh_pkg::MCBH_IDLE;
                    kind_d  = mcbh_pkg::MCBH_MV_NONE;
                end
            end
            default: begin
                // Unused state code: back to idle without a decel
                state_d = mcbh_pkg::MCBH_IDLE;
                kind_d  = mcbh_pkg::MCBH_MV_NONE;
            end
        endcase
    end

    // ==========================================================
    // Response status
    // Progressing follows the next state: it rises with the start
    // pulse and drops in the cycle the move ends or is stopped
    assign busy = (state_d == mcbh_pkg::MCBH_RUN);

    // Response status bytes; acks echo every frame, even when no
    // move could start, so only progressing shows real motion
    always_comb begin
        // Hold reaches the core only while a move runs
        hold_d = b2[mcbh_pkg::HoldBit] & running;
        st2_d  = mcbh_pkg::StatReset;
        st2_d[7:3] = b2[7:3];
        st2_d[mcbh_pkg::HoldRBit] = b2[mcbh_pkg::HoldBit] & (running | hold_q);
        st2_d[mcbh_pkg::BusyBit]  = busy;
        st3_d  = mcbh_pkg::StatReset;
        st3_d[mcbh_pkg::FwdBit]   = forwardLimitInput;
        st3_d[mcbh_pkg::NotBit]   = reverseLimitInput;
        st3_d[mcbh_pkg::InPosBit] = inPositionFlag;
        st3_d[mcbh_pkg::NearBit]  = nearFlag;
        st3_d[mcbh_pkg::HomePBit] = homePositionFlag;
        st3_d[mcbh_pkg::DirBit]   = b3[mcbh_pkg::DirBit];
        st3_d[mcbh_pkg::IncBit]   = b3[mcbh_pkg::IncBit];
    end

    // Status registers, one cycle behind the frame
    always_ff @(posedge clock) begin
        if (!nrst) begin
            hold_q <= 1'b0;
            st2_q  <= mcbh_pkg::StatReset;
            st3_q  <= mcbh_pkg::StatReset;
        end else begin
            hold_q <= hold_d;
            st2_q  <= st2_d;
            st3_q  <= st3_d;
        end
    end

    // ==========================================================
    // Registers
    always_ff @(posedge clock) begin
        if (!nrst) begin
            state_q <= mcbh_pkg::MCBH_IDLE;
            kind_q  <= mcbh_pkg::MCBH_MV_NONE;
            start_q <= 1'b0;
            decel_q <= 1'b0;
            neg_q   <= 1'b0;
            rel_q   <= 1'b0;
            dist_q  <= '0;
            tgt_q   <= '0;
            omode_q <= 4'h0;
        end else begin
            state_q <= state_d;
            kind_q  <= kind_d;
            start_q <= start_d;
            decel_q <= decel_d;
            neg_q   <= neg_d;
            rel_q   <= rel_d;
            dist_q  <= dist_d;
            tgt_q   <= tgt_d;
            omode_q <= omode_d;
        end
    end

    // ==========================================================
    // Outputs
    // Outputs straight from flip-flops, free of decode glitches
    assign moveStart      = start_q;
    assign moveKind       = kind_q;
    assign moveDecel      = decel_q;
    assign moveHold       = hold_q;
    assign moveNegative   = neg_q;
    assign moveRelative   = rel_q;
    assign moveDistance   = dist_q;
    assign moveTarget     = tgt_q;
    assign moveOriginMode = omode_q;
    assign statusByte2    = st2_q;
    assign statusByte3    = st3_q;
endmodule

//--- test/mcbh_motion_model.sv
// ==========================================================
// Motion core stand-in: finishes a move runLen cycles after
// its start and reports a stop three cycles after a decel.
module mcbh_motion_model (
    input  wire logic       clock,
    input  wire logic       nrst,
    input  wire logic       moveStart,
    input  wire logic       moveDecel,
    input  wire logic [7:0] runLen,
    output logic            motionDone,
    output logic            motionStopped
);
    timeunit 1ns;
    timeprecision 1ps;

    logic [7:0] runCnt_q;
    logic [7:0] runCnt_d;
    logic [1:0] stopCnt_q;
    logic [1:0] stopCnt_d;

    // Zero runLen gives an endless move, so only a decel ends it
    always_comb begin
        runCnt_d = runCnt_q;
        stopCnt_d = stopCnt_q;
        if (moveStart) begin
            runCnt_d = runLen;
        end else if (moveDecel) begin
            runCnt_d = 8'h00;
            stopCnt_d = 2'h3;
        end else begin
            if (runCnt_q != 8'h00) runCnt_d = runCnt_q - 8'h01;
            if (stopCnt_q != 2'h0) stopCnt_d = stopCnt_q - 2'h1;
        end
    end

    // Counter registers
    always_ff @(posedge clock) begin
        runCnt_q <= nrst ? runCnt_d : 8'h00;
        stopCnt_q <= nrst ? stopCnt_d : 2'h0;
    end

    // Single-cycle reports, low at all other times
    assign motionDone = (runCnt_q == 8'h01);
    assign motionStopped = (stopCnt_q == 2'h1);
endmodule

//--- test/mcbh_top_props.sv
// ==========================================================
// Port-level checks of the move command handler
module mcbh_top_props (
    input wire logic        clock,
    input wire logic        nrst,
    input wire logic        frameValid,
    input wire logic [7:0]  cmdByte2,
    input wire logic [7:0]  cmdByte3,
    input wire logic [31:0] cmdData,
    input wire logic [31:0] presetDistance0,
    input wire logic [31:0] presetDistance1,
    input wire logic [31:0] presetDistance2,
    input wire logic [31:0] presetDistance3,
    input wire logic        motionDone,
    input wire logic        moveStart,
    input wire logic [2:0]  moveKind,
    input wire logic        moveDecel,
    input wire logic        moveNegative,
    input wire logic        moveRelative,
    input wire logic [31:0] moveDistance,
    input wire logic [7:0]  statusByte2,
    input wire logic [7:0]  statusByte3
);
    timeunit 1ns;
    timeprecision 1ps;

    logic [7:0]  prevByte2_q;
    logic [7:0]  prevByte2_d;
    logic [31:0] pickDist;
    logic [7:0]  kindMask;
    logic        riseAny;

    // Last frame's byte 2; edges are seen only against a frame
    always_comb prevByte2_d = frameValid ? cmdByte2 : prevByte2_q;
    always_ff @(posedge clock) prevByte2_q <= nrst ? prevByte2_d : 8'h00;

    // Selected preset, command bit of the running kind, move edges
    always_comb begin
        case (cmdData[1:0])
            2'h0: pickDist = presetDistance0;
            2'h1: pickDist = presetDistance1;
            2'h2: pickDist = presetDistance2;
            default: pickDist = presetDistance3;
        endcase
        case (moveKind)
            mcbh_pkg::MCBH_MV_JOG: kindMask = 8'h08;
            mcbh_pkg::MCBH_MV_STEP: kindMask = 8'h10;
            mcbh_pkg::MCBH_MV_STA: kindMask = 8'h20;
            mcbh_pkg::MCBH_MV_TBL: kindMask = 8'h40;
            mcbh_pkg::MCBH_MV_HOME: kindMask = 8'h80;
            default: kindMask = 8'h00;
        endcase
        riseAny = frameValid && |(cmdByte2[7:3] & ~prevByte2_q[7:3]);
    end

    default clocking @(posedge clock); endclocking
    default disable iff (!nrst);

    a_ack_echo: assert property (frameValid |=>
        statusByte2[7:3] == $past(cmdByte2[7:3]))
        else $error("ack flags differ from command bits");
    a_zero_bits: assert property (
        statusByte2[2] == 1'b0 && statusByte3[2] == 1'b0)
        else $error("reserved status bit set");
    a_sel_echo: assert property (frameValid |=>
        statusByte3[1:0] == $past(cmdByte3[1:0]))
        else $error("direction or relative echo wrong");
    a_start_edge: assert property (
        moveStart |-> $past(riseAny))
        else $error("move started without a rising command bit");
    a_preset_pick: assert property (
        moveStart && moveKind == mcbh_pkg::MCBH_MV_STEP
        |-> moveDistance == $past(pickDist))
        else $error("wrong preset distance");
    a_dir_latch: assert property (moveStart |->
        moveNegative == ($past(cmdByte3[mcbh_pkg::DirBit]) &&
        moveKind inside {mcbh_pkg::MCBH_MV_JOG, mcbh_pkg::MCBH_MV_STEP,
                         mcbh_pkg::MCBH_MV_STA}))
        else $error("move direction wrong");
    a_sta_rel: assert property (
        moveStart && moveKind == mcbh_pkg::MCBH_MV_STA
        |-> moveRelative == $past(cmdByte3[mcbh_pkg::IncBit]))
        else $error("station relative selection wrong");
    a_decel_fall: assert property (
        frameValid && statusByte2[0] && !motionDone &&
        (kindMask & ~cmdByte2) != 8'h00 |=> moveDecel && !statusByte2[0])
        else $error("falling command bit did not stop the move");
    a_progressing_flag_start: assert property (moveStart |-> statusByte2[0])
        else $error("progressing flag low at move start");
    a_hold_flag: assert property (
        frameValid && cmdByte2[mcbh_pkg::HoldBit] && statusByte2[0] &&
        !motionDone && (kindMask & ~cmdByte2) == 8'h00 |=> statusByte2[1])
        else $error("holding flag not set");
endmodule

bind mcbh_top mcbh_top_props u_props (.*);

//--- test/testbench.sv
// ==========================================================
// Frame-level bench of the move command handler
module testbench;
    timeunit 1ns;
    timeprecision 1ps;

    logic        clock;
    logic        nrst;
    logic        frameValid;
    logic [7:0]  cmdByte2;
    logic [7:0]  cmdByte3;
    logic [31:0] cmdData;
    logic [31:0] presetDistance0;
    logic [31:0] presetDistance1;
    logic [31:0] presetDistance2;
    logic [31:0] presetDistance3;
    logic [3:0]  originSearchModeParam;
    logic        servoReady;
    logic        motionDone;
    logic        motionStopped;
    logic        homePositionFlag;
    logic        nearFlag;
    logic        inPositionFlag;
    logic        reverseLimitInput;
    logic        forwardLimitInput;
    logic        moveStart;
    logic [2:0]  moveKind;
    logic        moveDecel;
    logic        moveHold;
    logic        moveNegative;
    logic        moveRelative;
    logic [31:0] moveDistance;
    logic [31:0] moveTarget;
    logic [3:0]  moveOriginMode;
    logic [7:0]  statusByte2;
    logic [7:0]  statusByte3;
    logic [7:0]  runLen;
    logic [31:0] preset [4];
    logic [7:0]  acks [5];
    int          mismatches;
    int          checkCount;

    mcbh_top dut (.*);
    mcbh_motion_model u_motion (.*);

    // Free-running 200 MHz clock
    initial begin
        clock = 1'b0;
        forever #2.5 clock = ~clock;
    end

    task automatic chk(input logic [31:0] seen, input logic [31:0] exp,
                       input string nm);
        checkCount++;
        if (seen !== exp) begin
            mismatches++;
            $display("Error %s expected %h seen %h", nm, exp, seen);
        end
    endtask

    task automatic closeOut;
        $display("Checks %0d mismatches %0d", checkCount, mismatches);
        if (mismatches == 0 && checkCount > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask

    // One frame; returns just after the answering edge settles
    task automatic send(input logic [7:0] b2, input logic [7:0] b3,
                        input logic [31:0] d);
        @(posedge clock);
        frameValid <= 1'b1;
        cmdByte2 <= b2;
        cmdByte3 <= b3;
        cmdData <= d;
        @(posedge clock);
        frameValid <= 1'b0;
        #1;
    endtask

    // Bounded wait for the handler to drop the move kind
    task automatic waitIdle;
        int n;
        n = 0;
        while (moveKind !== 3'h0) begin
            if (n++ == 40) begin
                mismatches++;
                closeOut;
            end
            @(posedge clock);
            #1;
        end
    endtask

    task automatic startMv(input logic [7:0] b2, input logic [7:0] b3,
                           input logic [31:0] d, input logic [2:0] kind);
        send(b2, b3, d);
        chk(moveStart, 1, "moveStart");
        chk(moveKind, kind, "moveKind");
        chk(statusByte2, {b2[7:3], 3'h1}, "statusByte2 run");
    endtask

    // Falling command bit: decel pulse, progressing cleared
    task automatic stopMv;
        send(8'h00, 8'h00, 32'h0);
        chk(moveDecel, 1, "moveDecel");
        chk(statusByte2, 0, "statusByte2 stop");
        waitIdle;
    endtask

    // Main sequence
    initial begin
        preset = '{32'h0000_0010, 32'h0000_0200, 32'h0000_3000,
                   32'h0004_0000};
        acks = '{8'h08, 8'h10, 8'h20, 8'h40, 8'h80};
        {presetDistance0, presetDistance1} = {preset[0], preset[1]};
        {presetDistance2, presetDistance3} = {preset[2], preset[3]};
        {nrst, frameValid, cmdByte2, cmdByte3, cmdData} = '0;
        {homePositionFlag, nearFlag, inPositionFlag} = 3'h0;
        {reverseLimitInput, forwardLimitInput} = 2'h0;
        originSearchModeParam = 4'h5;
        servoReady = 1'b1;
        runLen = 8'h04;
        mismatches = 0;
        checkCount = 0;
        repeat (2) @(posedge clock);
        nrst <= 1'b1;
        @(posedge clock);
        #1;
        chk(statusByte2, 0, "statusByte2 reset");
        chk(moveKind, 0, "moveKind reset");
        // Every preset selector and both directions, run to the end
        for (int i = 0; i < 4; i++) begin
            startMv(8'h10, i[0] ? 8'h02 : 8'h00, i, mcbh_pkg::MCBH_MV_STEP);
            chk(moveDistance, preset[i], "moveDistance");
            chk(moveNegative, i[0], "moveNegative");
            waitIdle;
            chk(statusByte2, 8'h10, "statusByte2 done");
            send(8'h00, 8'h00, 32'h0);
        end
        // Endless moves, each cut short by its falling bit
        @(posedge clock);
        runLen <= 8'h00;
        {forwardLimitInput, inPositionFlag, homePositionFlag} <= 3'h7;
        startMv(8'h20, 8'h03, 32'h5, mcbh_pkg::MCBH_MV_STA);
        chk(moveTarget, 32'h5, "moveTarget");
        chk(moveRelative, 1, "moveRelative");
        chk(moveNegative, 1, "moveNegative");
        chk(statusByte3, 8'hab, "statusByte3");
        stopMv;
        startMv(8'h40, 8'h02, 32'h7, mcbh_pkg::MCBH_MV_TBL);
        chk(moveNegative, 0, "moveNegative");
        chk(moveRelative, 0, "moveRelative");
        chk(moveTarget, 32'h7, "moveTarget");
        stopMv;
        startMv(8'h80, 8'h00, 32'h0, mcbh_pkg::MCBH_MV_HOME);
        chk(moveOriginMode, 4'h5, "moveOriginMode");
        stopMv;
        // Cancel ends a move whose bit stays set; other status inputs
        @(posedge clock);
        {reverseLimitInput, nearFlag, forwardLimitInput} <= 3'h6;
        {inPositionFlag, homePositionFlag} <= 2'h0;
        startMv(8'h20, 8'h01, 32'h3, mcbh_pkg::MCBH_MV_STA);
        chk(statusByte3, 8'h51, "statusByte3 low");
        send(8'h21, 8'h01, 32'h3);
        chk(moveDecel, 1, "moveDecel cancel");
        chk(statusByte2, 8'h20, "statusByte2 cancel");
        waitIdle;
        send(8'h00, 8'h00, 32'h0);
        startMv(8'h08, 8'h02, 32'h0, mcbh_pkg::MCBH_MV_JOG);
        chk(moveNegative, 1, "moveNegative");
        send(8'h0a, 8'h02, 32'h0);
        chk(statusByte2[1], 1, "holding flag");
        chk(moveHold, 1, "moveHold");
        send(8'h08, 8'h02, 32'h0);
        chk(statusByte2[1], 0, "holding flag off");
        chk(moveHold, 0, "moveHold off");
        stopMv;
        // Servo off: no start, acknowledges still follow
        @(posedge clock);
        servoReady <= 1'b0;
        foreach (acks[k]) begin
            send(acks[k], 8'h00, 32'h0);
            chk(moveStart, 0, "moveStart refused");
            chk(statusByte2, acks[k], "statusByte2 ack");
            send(8'h00, 8'h00, 32'h0);
        end
        closeOut;
    end
endmodule
